// *** pmv_consts.svh ***
// Constants for the program memory and vectoring block
`ifndef PMV_CONSTS_SVH
`define PMV_CONSTS_SVH
`define PMV_RESET_VECTOR 12'h000
`define PMV_INT_VECTOR 12'h008
`define PMV_GP_START 12'h010
`define PMV_RESERVED_ADDR 12'hFFF
`define PMV_ADDR_CTRL 12'h000
`define PMV_ADDR_ACC 12'h004
`define PMV_ADDR_PSR 12'h008
`define PMV_ADDR_PTRH 12'h00C
`define PMV_ADDR_PTRL 12'h010
`define PMV_ADDR_RES 12'h014
`define PMV_ADDR_PC 12'h018
`define PMV_ADDR_STACK 12'h01C
`define PMV_ADDR_ROMWIN 12'h020
`define PMV_ADDR_SAVED 12'h024
`define PMV_CMD_INT 0
`define PMV_CMD_INTERRUPT_RETURN_INSTR 1
`define PMV_CMD_PUSH 2
`define PMV_CMD_POP 3
`define PMV_CMD_READ 4
`define PMV_CMD_ADDZ 5
`define PMV_CMD_STEP 6
`define PMV_CMD_WDT 7
`define PMV_CMD_EXTRST 8
`define PMV_FLAG_A 7
`define PMV_FLAG_B 6
`define PMV_FLAG_C 2
`define PMV_PSR_SAVE_MASK 8'h3F
`define PMV_RST_CAUSE_POR 2'b10
`define PMV_RST_CAUSE_WDT 2'b00
`define PMV_RST_CAUSE_EXT 2'b11
`endif

// *** pmv_core.sv ***
// Program memory, vectoring, save buffer and table read over AHB-Lite
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pmv_consts.svh"
module pmv_core
  import pmv_pkg::*;
#(
  parameter int ROM_WORDS = 4096,
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [AW-1:0] rom_addr,
  output logic rom_req,
  input wire logic [15:0] rom_data,
  input wire logic por_flag_n
);
  logic [7:0] acc_reg;
  logic [7:0] psr_reg;
  logic [7:0] ptrh_reg;
  logic [7:0] ptrl_reg;
  logic [7:0] res_reg;
  logic [AW-1:0] pc_reg;
  logic [AW-1:0] stack_reg;
  pmv_save_t save_reg;
  pmv_state_t state_reg;
  logic [31:0] hrdata_reg;
  logic [AW-1:0] rom_addr_reg;
  logic rom_req_reg;
  logic ap_wr_reg;
  logic [11:0] ap_addr_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [AW-1:0] pc_next;
  logic soft_rst_reg;
  logic [1:0] soft_cause_reg;
  logic por_s1_reg;
  logic por_s2_reg;
  logic por_done_reg;

  // Address phase capture
  wire logic ap_valid = hsel & hready & htrans[1];
  wire logic wr_now = ap_wr_reg;
  wire logic [11:0] wa = ap_addr_reg;
  wire logic [8:0] cmd = hwdata[8:0];
  wire logic do_ctrl = wr_now && (wa == `PMV_ADDR_CTRL);
  wire logic do_int = do_ctrl && cmd[`PMV_CMD_INT];
  wire logic do_interrupt_return_instr = do_ctrl && !cmd[`PMV_CMD_INT] && cmd[`PMV_CMD_INTERRUPT_RETURN_INSTR];
  wire logic do_push = do_ctrl && cmd[`PMV_CMD_PUSH];
  wire logic do_pop = do_ctrl && !cmd[`PMV_CMD_PUSH] && cmd[`PMV_CMD_POP];
  wire logic do_read = do_ctrl && cmd[`PMV_CMD_READ] && (state_reg == PMV_IDLE);
  wire logic do_addz = do_ctrl && cmd[`PMV_CMD_ADDZ];
  wire logic do_step = do_ctrl && cmd[`PMV_CMD_STEP];
  wire logic do_wdt = do_ctrl && cmd[`PMV_CMD_WDT];
  wire logic do_ext = do_ctrl && cmd[`PMV_CMD_EXTRST];
  wire logic [15:0] table_ptr = {ptrh_reg, ptrl_reg};
  wire logic [8:0] addz_sum = {1'b0, ptrl_reg} + {1'b0, acc_reg};
  wire logic [AW-1:0] pc_inc = pc_reg + 1'b1;
  wire logic in_reserved = (pc_inc == `PMV_RESERVED_ADDR);

  // Register select decode
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : reg_hit

  // Write selects, data phase
  wire logic wr_acc = wr_now && reg_hit(wa, `PMV_ADDR_ACC);
  wire logic wr_psr = wr_now && reg_hit(wa, `PMV_ADDR_PSR);
  wire logic wr_ptrh = wr_now && reg_hit(wa, `PMV_ADDR_PTRH);
  wire logic wr_ptrl = wr_now && reg_hit(wa, `PMV_ADDR_PTRL);
  wire logic wr_res = wr_now && reg_hit(wa, `PMV_ADDR_RES);
  wire logic wr_pc = wr_now && reg_hit(wa, `PMV_ADDR_PC);

  // Read selects, address phase
  wire logic [11:0] ra = haddr[11:0];
  wire logic rd_acc = reg_hit(ra, `PMV_ADDR_ACC);
  wire logic rd_psr = reg_hit(ra, `PMV_ADDR_PSR);
  wire logic rd_ptrh = reg_hit(ra, `PMV_ADDR_PTRH);
  wire logic rd_ptrl = reg_hit(ra, `PMV_ADDR_PTRL);
  wire logic rd_res = reg_hit(ra, `PMV_ADDR_RES);
  wire logic rd_pc = reg_hit(ra, `PMV_ADDR_PC);
  wire logic rd_stack = reg_hit(ra, `PMV_ADDR_STACK);
  wire logic rd_saved = reg_hit(ra, `PMV_ADDR_SAVED);
  wire logic rd_ctrl = reg_hit(ra, `PMV_ADDR_CTRL);

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rd_acc) begin
      rd_mux = {24'h000000, acc_reg};
    end else if (rd_psr) begin
      rd_mux = {24'h000000, psr_reg};
    end else if (rd_ptrh) begin
      rd_mux = {24'h000000, ptrh_reg};
    end else if (rd_ptrl) begin
      rd_mux = {24'h000000, ptrl_reg};
    end else if (rd_res) begin
      rd_mux = {24'h000000, res_reg};
    end else if (rd_pc) begin
      rd_mux = {{(32-AW){1'b0}}, pc_reg};
    end else if (rd_stack) begin
      rd_mux = {{(32-AW){1'b0}}, stack_reg};
    end else if (rd_saved) begin
      rd_mux = {16'h0000, save_reg};
    end else if (rd_ctrl) begin
      rd_mux = {29'h00000000, state_reg};
    end
  end

  // Program counter next value
  always_comb begin
    pc_next = pc_reg;
    if (do_int) begin
      pc_next = `PMV_INT_VECTOR;
    end else if (do_interrupt_return_instr) begin
      pc_next = stack_reg;
    end else if (do_step) begin
      pc_next = in_reserved ? `PMV_GP_START : pc_inc;
    end else if (wr_pc) begin
      pc_next = hwdata[AW-1:0];
    end
  end

  // Bus phase registers, read data launched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      ap_wr_reg <= ap_valid & hwrite;
      ap_addr_reg <= haddr[11:0];
      hrdata_reg <= hrdata_reg;
      if (ap_valid && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // Bus response, no wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // Power-on strap synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
      por_done_reg <= 1'b0;
    end else begin
      por_s1_reg <= por_flag_n;
      por_s2_reg <= por_s1_reg;
      por_done_reg <= 1'b1;
    end
  end

  // Software-triggered restart (watchdog or external)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_rst_reg <= 1'b0;
      soft_cause_reg <= `PMV_RST_CAUSE_POR;
    end else begin
      soft_rst_reg <= do_wdt | do_ext;
      soft_cause_reg <= do_ext ? `PMV_RST_CAUSE_EXT : `PMV_RST_CAUSE_WDT;
    end
  end

  // Save buffer, single level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      save_reg <= '0;
    end else if (soft_rst_reg) begin
      save_reg <= '0;
    end else if (do_push) begin
      save_reg <= '{working: acc_reg, status: psr_reg & `PMV_PSR_SAVE_MASK};
    end
  end

  // Interrupt return stack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_reg <= `PMV_RESET_VECTOR;
    end else if (soft_rst_reg) begin
      stack_reg <= `PMV_RESET_VECTOR;
    end else if (do_int) begin
      stack_reg <= pc_reg;
    end
  end

  // Table read sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= PMV_IDLE;
      rom_addr_reg <= `PMV_RESET_VECTOR;
      rom_req_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      state_reg <= PMV_IDLE;
      rom_addr_reg <= `PMV_RESET_VECTOR;
      rom_req_reg <= 1'b0;
    end else begin
      case (state_reg)
        PMV_IDLE: begin
          rom_req_reg <= 1'b0;
          if (do_read) begin
            rom_addr_reg <= table_ptr[AW-1:0];
            rom_req_reg <= 1'b1;
            state_reg <= PMV_FETCH;
          end
        end
        PMV_FETCH: begin
          rom_req_reg <= 1'b0;
          state_reg <= PMV_DONE;
        end
        PMV_DONE: begin
          state_reg <= PMV_IDLE;
        end
        default: begin
          state_reg <= PMV_IDLE;
        end
      endcase
    end
  end

  // Core state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= 8'h00;
      psr_reg <= {`PMV_RST_CAUSE_POR, 6'h00};
      ptrh_reg <= 8'h00;
      ptrl_reg <= 8'h00;
      res_reg <= 8'h00;
      pc_reg <= `PMV_RESET_VECTOR;
    end else if (soft_rst_reg) begin
      acc_reg <= 8'h00;
      psr_reg <= {soft_cause_reg, 6'h00};
      ptrh_reg <= 8'h00;
      ptrl_reg <= 8'h00;
      res_reg <= 8'h00;
      pc_reg <= `PMV_RESET_VECTOR;
    end else begin
      if (por_done_reg && !por_s2_reg) begin
        psr_reg[`PMV_FLAG_A] <= psr_reg[`PMV_FLAG_A];
      end
      pc_reg <= pc_next;
      if (do_pop) begin
        acc_reg <= save_reg.working;
        psr_reg <= (psr_reg & ~`PMV_PSR_SAVE_MASK)
          | (save_reg.status & `PMV_PSR_SAVE_MASK);
      end else if (do_addz) begin
        ptrl_reg <= addz_sum[7:0];
        psr_reg[`PMV_FLAG_C] <= addz_sum[8];
      end else if (state_reg == PMV_DONE) begin
        acc_reg <= rom_data[7:0];
        res_reg <= rom_data[15:8];
      end else if (wr_acc) begin
        acc_reg <= hwdata[7:0];
      end else if (wr_psr) begin
        psr_reg <= {psr_reg[7:6], hwdata[5:0]};
      end else if (wr_ptrh) begin
        ptrh_reg <= hwdata[7:0];
      end else if (wr_ptrl) begin
        ptrl_reg <= hwdata[7:0];
      end else if (wr_res) begin
        res_reg <= hwdata[7:0];
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign rom_addr = rom_addr_reg;
  assign rom_req = rom_req_reg;
endmodule : pmv_core

// *** pmv_core_properties.sv ***
// Port checker for the program memory and vectoring block
`timescale 1ns/1ps
module pmv_core_checker #(
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [AW-1:0] rom_addr,
  input wire logic rom_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wc_reg;
  logic rp_reg;
  wire req_take = hsel && hready && htrans[1];
  wire tr = wc_reg && hwdata[4];
  wire rs = wc_reg && (|hwdata[8:7]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wc_reg <= 1'b0;
      rp_reg <= 1'b0;
    end else begin
      wc_reg <= req_take && hwrite && (haddr[11:0] == 12'h000);
      rp_reg <= req_take && !hwrite;
    end
  end
  ready_always_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  req_pulse_a: assert property (rom_req |=> !rom_req) else $error("fetch request too long");
  req_after_cmd_a: assert property (tr && !rs |-> ##1 rom_req)
    else $error("table read not started");
  req_cause_a: assert property (rom_req |-> $past(tr))
    else $error("fetch without command");
  reset_quiet_a: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !rom_req)
    else $error("outputs not at default");
  addr_hold_a: assert property ($changed(rom_addr) |-> rom_req || $past(rs) || $past(rs, 2))
    else $error("table address moved");
  data_hold_a: assert property (!rp_reg && !$past(rs)
    && !$past(rs, 2) |-> $stable(hrdata)) else $error("read data moved");
endmodule : pmv_core_checker
bind pmv_core pmv_core_checker #(.AW(AW)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rom_addr(rom_addr),
  .rom_req(rom_req));

// *** pmv_pkg.sv ***
// Types for the program memory and vectoring block
package pmv_pkg;
  typedef struct packed {
    logic [7:0] working;
    logic [7:0] status;
  } pmv_save_t;
  typedef enum logic [2:0] {
    PMV_IDLE = 3'b001,
    PMV_FETCH = 3'b010,
    PMV_DONE = 3'b100
  } pmv_state_t;
endpackage : pmv_pkg

// *** test_program_memory_vectoring.sv ***
// Bench for the program memory and vectoring block
`timescale 1ns/1ps
module test_program_memory_vectoring;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic por_n = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] rom_data = 16'h0;
  logic [31:0] hrdata;
  logic [11:0] rom_addr;
  logic hreadyout, hresp, rom_req;
  wire hready = hreadyout;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rows [5][3] = '{'{32'h04, 32'h5A, 32'h5A}, '{32'h0C, 32'h12, 32'h12},
    '{32'h10, 32'h34, 32'h34}, '{32'h08, 32'hFF, 32'hBF}, '{32'h30, 32'hFF, 32'h00}};
  always #5 hclk = ~hclk;
  always @(posedge hclk) rom_data <= {rom_addr[7:0] ^ 8'hA5, rom_addr[11:4]};
  pmv_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rom_addr(rom_addr), .rom_req(rom_req),
    .rom_data(rom_data), .por_flag_n(por_n));
  task results;
    $display("Mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wt;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      chk("hreadyout", 32'h1, 32'h0);
      results;
    end
  endtask : wt
  task xfer(logic [31:0] a, logic w, logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wt;
    htrans <= 2'b00;
    hwdata <= d;
    wt;
  endtask : xfer
  task wr(logic [31:0] a, logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task rc(logic [31:0] a, logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a[7:0]), e, hrdata);
  endtask : rc
  task cmd(logic [31:0] d);
    wr(32'h0, d);
    repeat (4) @(posedge hclk);
  endtask : cmd
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rc(32'h18, 32'h0);
    rc(32'h08, 32'h80);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rc(rows[i][0], rows[i][2]);
    end
    wr(32'h0C, 32'h01);
    wr(32'h10, 32'h23);
    cmd(32'h10);
    chk("rom_addr", 32'h123, {20'h0, rom_addr});
    rc(32'h04, 32'h12);
    rc(32'h14, 32'h86);
    wr(32'h10, 32'hF0);
    wr(32'h04, 32'h20);
    wr(32'h08, 32'h00);
    cmd(32'h20);
    rc(32'h10, 32'h10);
    rc(32'h08, 32'h84);
    rc(32'h0C, 32'h01);
    wr(32'h04, 32'h11);
    cmd(32'h04);
    wr(32'h04, 32'h22);
    wr(32'h08, 32'h00);
    cmd(32'h08);
    rc(32'h04, 32'h11);
    rc(32'h08, 32'h84);
    cmd(32'h40);
    cmd(32'h40);
    cmd(32'h01);
    rc(32'h18, 32'h8);
    rc(32'h1C, 32'h2);
    cmd(32'h02);
    rc(32'h18, 32'h2);
    cmd(32'h80);
    rc(32'h18, 32'h0);
    rc(32'h08, 32'h00);
    cmd(32'h100);
    rc(32'h08, 32'hC0);
    rc(32'h04, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(32'h08, 32'h80);
    results;
  end
endmodule : test_program_memory_vectoring
